// [common/card_host_pkg.sv]
// Constants for the card host status and bus clock rate block
package card_host_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] CLKDIV_OFS = 8'h08;

    localparam int CTRL_CLK_LSB = 0;
    localparam int CTRL_START_OP_BIT = 2;
    localparam int CTRL_RESET_BIT = 3;

    localparam int ST_AUTO_STOP = 31;
    localparam int ST_RESETTING = 15;
    localparam int ST_SDIO_INT = 14;
    localparam int ST_CARD_PROGRAMMING_FINISHED = 13;
    localparam int ST_DATA_DONE = 12;
    localparam int ST_CMD_DONE = 11;
    localparam int ST_FIFO_AFULL = 10;
    localparam int ST_READ_PAUSE = 9;
    localparam int ST_CLK_ON = 8;
    localparam int ST_FIFO_FULL = 7;
    localparam int ST_FIFO_EMPTY = 6;
    localparam int ST_RESP_CRC = 5;
    localparam int ST_READ_CRC = 4;
    localparam int ST_WR_CRC_LSB = 2;
    localparam int ST_RESP_TO = 1;
    localparam int ST_READ_TO = 0;
    localparam logic [31:0] STAT_RESET = 32'h0000_0040;

    localparam int RATE_W = 3;
    localparam logic [2:0] RATE_RESET = 3'h7;

    localparam int FIFO_AFULL_WORDS = 15;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        CLK_CMD_NOP = 2'h0,
        CLK_CMD_STOP = 2'h1,
        CLK_CMD_START = 2'h2
    } clk_cmd_t;

    typedef enum logic [1:0] {
        WR_CRC_OK = 2'h0,
        WR_CRC_BAD = 2'h1,
        WR_CRC_NONE = 2'h2
    } wr_crc_t;

    typedef enum logic [1:0] {
        RST_BUSY = 2'h0,
        RST_DONE = 2'h1
    } rst_state_t;

    localparam int CLK_PERIOD_NS = 25;
    localparam int RESET_TIME_NS = 400;
    localparam int RESET_CYCLES =
        (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] RESET_CNT_LOAD = 8'(RESET_CYCLES - 1);
endpackage

// [rtl/card_clock_divider.sv]
// Power-of-two divider producing one tick per card bus clock period
`timescale 1ns/1ps
module card_clock_divider #(
    parameter int RATE_W = 3
) (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic run_in,
    input wire logic [RATE_W-1:0] rate_in,
    output logic tick_out
);
    localparam int CNT_W = (1 << RATE_W) - 1;

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] mask;
    logic wrap;

    // Low rate bits of the counter decide the period
    always_comb begin
        mask = CNT_W'((1 << rate_in) - 1);
        wrap = (count_reg & mask) == mask;
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_reg <= '0;
        end else if (!run_in || wrap) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // Rate zero ticks every cycle, passing the source clock
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= run_in && wrap;
        end
    end
endmodule

// [rtl/card_host_status.sv]
// Status register, reset sequencer and bus clock rate of the card host
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
module card_host_status (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rd_data_out,
    input wire logic auto_stop_done_in,
    input wire logic sdio_int_detect_in,
    input wire logic sdio_int_ack_in,
    input wire logic card_busy_in,
    input wire logic data_tran_done_in,
    input wire logic cmd_done_in,
    input wire logic [4:0] fifo_level_in,
    input wire logic card_in_read_pause_in,
    input wire logic resp_crc_err_in,
    input wire logic read_crc_err_in,
    input wire logic wr_crc_valid_in,
    input wire logic [1:0] wr_crc_code_in,
    input wire logic resp_timeout_in,
    input wire logic read_timeout_in,
    output logic ctrl_reset_out,
    output logic op_start_out,
    output logic card_clk_running_out,
    output logic card_clk_tick_out
);
    localparam int NEV = 7;

    logic ctrl_wr;
    logic stat_wr;
    logic div_wr;
    logic soft_reset_req;
    logic op_start_req;
    logic [1:0] clk_cmd;
    logic flag_clear;

    card_host_pkg::rst_state_t rst_state_reg;
    card_host_pkg::rst_state_t rst_state_next;
    logic [7:0] rst_cnt_reg;
    logic resetting;

    logic [NEV-1:0] ev;
    logic [NEV-1:0] sticky_reg;
    logic sdio_int_reg;
    logic card_programming_finished_reg;
    logic read_pause_reg;
    logic [2:0] fifo_flags_reg;
    logic [1:0] wr_crc_reg;
    logic clk_run_reg;
    logic [2:0] rate_reg;
    logic [31:0] status_word;
    logic [31:0] rd_data_next;

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] ofs);
        hit = a == ofs;
    endfunction

    // Register decode
    always_comb begin
        ctrl_wr = wr_in && hit(addr_in, card_host_pkg::CTRL_OFS);
        stat_wr = wr_in && hit(addr_in, card_host_pkg::STAT_OFS);
        div_wr = wr_in && hit(addr_in, card_host_pkg::CLKDIV_OFS);
        soft_reset_req = ctrl_wr
            && wr_data_in[card_host_pkg::CTRL_RESET_BIT];
        op_start_req = ctrl_wr && !resetting
            && wr_data_in[card_host_pkg::CTRL_START_OP_BIT];
        clk_cmd = wr_data_in[card_host_pkg::CTRL_CLK_LSB +: 2];
        flag_clear = op_start_req || resetting;
    end

    // Reset sequencer, busy after power-up and after a reset request
    always_comb begin
        case (rst_state_reg)
            card_host_pkg::RST_BUSY: begin
                rst_state_next = (rst_cnt_reg == 8'h00)
                    ? card_host_pkg::RST_DONE : card_host_pkg::RST_BUSY;
            end
            card_host_pkg::RST_DONE: begin
                rst_state_next = card_host_pkg::RST_DONE;
            end
            default: begin
                rst_state_next = card_host_pkg::RST_BUSY;
            end
        endcase
        if (soft_reset_req) begin
            rst_state_next = card_host_pkg::RST_BUSY;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_state_reg <= card_host_pkg::RST_BUSY;
        end else begin
            rst_state_reg <= rst_state_next;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_cnt_reg <= card_host_pkg::RESET_CNT_LOAD;
        end else if (soft_reset_req) begin
            rst_cnt_reg <= card_host_pkg::RESET_CNT_LOAD;
        end else if (rst_cnt_reg != 8'h00) begin
            rst_cnt_reg <= rst_cnt_reg - 8'h01;
        end
    end

    assign resetting = rst_state_reg == card_host_pkg::RST_BUSY;
    assign ctrl_reset_out = resetting;

    // Operation start pulse to the command engine
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            op_start_out <= 1'b0;
        end else begin
            op_start_out <= op_start_req;
        end
    end

    // Sticky completion and error flags; a set wins over the operation start clear
    assign ev = {auto_stop_done_in, data_tran_done_in, cmd_done_in,
                 resp_crc_err_in, read_crc_err_in, resp_timeout_in,
                 read_timeout_in};

    genvar gi;
    generate
        for (gi = 0; gi < NEV; gi++) begin : g_sticky
            always_ff @(posedge ref_clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    sticky_reg[gi] <= 1'b0;
                end else if (ev[gi] && !resetting) begin
                    sticky_reg[gi] <= 1'b1;
                end else if (flag_clear) begin
                    sticky_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Card interrupt held until the acknowledge command goes out
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sdio_int_reg <= 1'b0;
        end else if (sdio_int_detect_in && !resetting) begin
            sdio_int_reg <= 1'b1;
        end else if (sdio_int_ack_in || resetting) begin
            sdio_int_reg <= 1'b0;
        end
    end

    // Level flags follow the card and FIFO state
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            card_programming_finished_reg <= 1'b0;
            read_pause_reg <= 1'b0;
        end else begin
            card_programming_finished_reg <= !card_busy_in && !resetting;
            read_pause_reg <= card_in_read_pause_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fifo_flags_reg <= 3'h1;
        end else begin
            fifo_flags_reg[0] <= fifo_level_in == 5'h00;
            fifo_flags_reg[1] <= 32'(fifo_level_in)
                >= card_host_pkg::FIFO_DEPTH;
            fifo_flags_reg[2] <= 32'(fifo_level_in)
                >= card_host_pkg::FIFO_AFULL_WORDS;
        end
    end

    // Write CRC status code, reserved code never stored
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_crc_reg <= card_host_pkg::WR_CRC_OK;
        end else if (wr_crc_valid_in && !resetting
                     && wr_crc_code_in != 2'h3) begin
            wr_crc_reg <= wr_crc_code_in;
        end else if (flag_clear) begin
            wr_crc_reg <= card_host_pkg::WR_CRC_OK;
        end
    end

    // Bus clock run state from the clock command
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            clk_run_reg <= 1'b0;
        end else if (resetting) begin
            clk_run_reg <= 1'b0;
        end else if (ctrl_wr && clk_cmd == card_host_pkg::CLK_CMD_STOP) begin
            clk_run_reg <= 1'b0;
        end else if (ctrl_wr && clk_cmd == card_host_pkg::CLK_CMD_START) begin
            clk_run_reg <= 1'b1;
        end
    end

    assign card_clk_running_out = clk_run_reg;

    // Divider setting, only the rate field is writable
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rate_reg <= card_host_pkg::RATE_RESET;
        end else if (div_wr) begin
            rate_reg <= wr_data_in[2:0];
        end
    end

    card_clock_divider #(
        .RATE_W(card_host_pkg::RATE_W)
    ) u_div (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .run_in(clk_run_reg),
        .rate_in(rate_reg),
        .tick_out(card_clk_tick_out)
    );

    // Status word assembly; writes to it are ignored
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[card_host_pkg::ST_AUTO_STOP] = sticky_reg[6];
        status_word[card_host_pkg::ST_RESETTING] = resetting;
        status_word[card_host_pkg::ST_SDIO_INT] = sdio_int_reg;
        status_word[card_host_pkg::ST_CARD_PROGRAMMING_FINISHED] = card_programming_finished_reg;
        status_word[card_host_pkg::ST_DATA_DONE] = sticky_reg[5];
        status_word[card_host_pkg::ST_CMD_DONE] = sticky_reg[4];
        status_word[card_host_pkg::ST_FIFO_AFULL] = fifo_flags_reg[2];
        status_word[card_host_pkg::ST_READ_PAUSE] = read_pause_reg;
        status_word[card_host_pkg::ST_CLK_ON] = clk_run_reg;
        status_word[card_host_pkg::ST_FIFO_FULL] = fifo_flags_reg[1];
        status_word[card_host_pkg::ST_FIFO_EMPTY] = fifo_flags_reg[0];
        status_word[card_host_pkg::ST_RESP_CRC] = sticky_reg[3];
        status_word[card_host_pkg::ST_READ_CRC] = sticky_reg[2];
        status_word[card_host_pkg::ST_WR_CRC_LSB +: 2] = wr_crc_reg;
        status_word[card_host_pkg::ST_RESP_TO] = sticky_reg[1];
        status_word[card_host_pkg::ST_READ_TO] = sticky_reg[0];
    end

    // Read data, one cycle after the strobe, zero when unmapped
    always_comb begin
        rd_data_next = 32'h0000_0000;
        if (rd_in && hit(addr_in, card_host_pkg::STAT_OFS)) begin
            rd_data_next = status_word;
        end else if (rd_in && hit(addr_in, card_host_pkg::CLKDIV_OFS)) begin
            rd_data_next = {29'h0, rate_reg};
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_data_out <= 32'h0000_0000;
        end else begin
            rd_data_out <= rd_data_next;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rstn_in);

    logic unused_stat_wr;
    assign unused_stat_wr = stat_wr;

    chk_auto_stop_set: assert property (
        auto_stop_done_in && !resetting |=> status_word[31]
    ) else $error("auto stop flag not set");

    chk_reset_busy_run: assert property (
        soft_reset_req |=> status_word[15] [*8]
    ) else $error("reset flag dropped early");

    chk_reset_ends: assert property (
        resetting && rst_cnt_reg == 8'h00 && !soft_reset_req
            |=> !status_word[15] && !ctrl_reset_out
    ) else $error("reset flag not released");

    chk_sdio_hold: assert property (
        sdio_int_reg && !sdio_int_ack_in && !resetting
            |=> status_word[14]
    ) else $error("card interrupt lost before acknowledge");

    chk_sdio_ack: assert property (
        sdio_int_ack_in && !sdio_int_detect_in |=> !status_word[14]
    ) else $error("card interrupt not cleared by acknowledge");

    chk_card_programming_finished: assert property (
        !resetting && card_busy_in |=> !status_word[13]
    ) else $error("programming done while card busy");

    chk_cmd_done_hold: assert property (
        status_word[11] && !flag_clear |=> status_word[11]
    ) else $error("command done flag lost");

    chk_fifo_afull: assert property (
        fifo_level_in >= 5'h0F |=> status_word[10]
    ) else $error("almost full not shown");

    chk_fifo_below: assert property (
        fifo_level_in < 5'h0F |=> !status_word[10] && !status_word[7]
    ) else $error("fifo level flag wrong below fifteen");

    chk_fifo_empty: assert property (
        fifo_level_in == 5'h00 |=> status_word[6]
    ) else $error("empty flag not shown");

    chk_write_crc_code: assert property (
        status_word[3:2] != 2'h3
    ) else $error("reserved write crc code shown");

    chk_resp_to: assert property (
        resp_timeout_in && !resetting |=> status_word[1]
            ##1 (status_word[1] || $past(flag_clear))
    ) else $error("response timeout not held");

    chk_clock_stop: assert property (
        ctrl_wr && clk_cmd == 2'h1 |=> !status_word[8] ##1
            !card_clk_tick_out
    ) else $error("bus clock still runs after stop");

    chk_clock_pass: assert property (
        clk_run_reg && rate_reg == 3'h0 [*2] |=> card_clk_tick_out
    ) else $error("rate zero does not pass source clock");

    chk_clock_slow: assert property (
        clk_run_reg && rate_reg == 3'h7 && $rose(card_clk_tick_out)
            ##1 (clk_run_reg && rate_reg == 3'h7) [*8]
            |-> !card_clk_tick_out
    ) else $error("rate seven ticks too often");

    chk_div_read: assert property (
        rd_in && addr_in == 8'h08 |=> rd_data_out[31:3] == 29'h0
            && rd_data_out[2:0] == $past(rate_reg)
    ) else $error("divider read shows reserved bits");

    chk_stat_read: assert property (
        rd_in && addr_in == 8'h04 |=> rd_data_out == $past(status_word)
    ) else $error("status read mismatch");
endmodule

// [testbench/card_side_model.sv]
// Card side model: card events, card status levels, bus clock tick count
`timescale 1ns/1ps
module card_side_model (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic [8:0] ev_in,
    input wire logic [1:0] code_in,
    input wire logic busy_in,
    input wire logic pause_in,
    input wire logic tick_in,
    output logic [8:0] pulse_out,
    output logic [1:0] code_out,
    output logic busy_out,
    output logic pause_out,
    output logic [15:0] ticks_out
);
    // Each card event reaches the host as a one-cycle pulse
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pulse_out <= '0;
        end else begin
            pulse_out <= ev_in;
        end
    end
    // CRC status code is only meaningful beside its pulse
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            code_out <= 2'h3;
        end else begin
            code_out <= ev_in[6] ? code_in : ~code_out;
        end
    end
    // Programming busy and read pause are card levels
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            busy_out <= 1'b0;
            pause_out <= 1'b0;
        end else begin
            busy_out <= busy_in;
            pause_out <= pause_in;
        end
    end
    // Counts bus clock periods seen by the card
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ticks_out <= 16'h0000;
        end else if (tick_in) begin
            ticks_out <= ticks_out + 16'h0001;
        end
    end
endmodule

// [testbench/card_host_status_tb.sv]
// Self-checking bench for the card host status block
`timescale 1ns/1ps
module card_host_status_tb;
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ack = 1'b0;
    logic [4:0] level = 5'h00;
    logic [8:0] ev = 9'h000;
    logic [1:0] code = 2'h0;
    logic busy = 1'b0;
    logic pause = 1'b0;
    logic [31:0] rdata;
    logic [8:0] pulse;
    logic [1:0] code_c;
    logic busy_c;
    logic pause_c;
    logic tick;
    logic rst_o;
    logic op_o;
    logic run_o;
    logic [15:0] ticks;
    logic [15:0] t0;
    logic [31:0] got;
    int fail_count = 0;
    int samples_checked = 0;
    int bit_of[9] = '{31, 14, 12, 11, 5, 4, 3, 1, 0};
    logic [4:0] lv[5] = '{5'h00, 5'h01, 5'h0E, 5'h0F, 5'h10};
    logic [31:0] lx[5] = '{32'h2040, 32'h2000, 32'h2000, 32'h2400,
        32'h2480};
    localparam logic [31:0] IDLE = 32'h0000_2040;

    initial begin
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end

    card_host_status dut_u (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
        .addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd),
        .rd_data_out(rdata), .auto_stop_done_in(pulse[0]),
        .sdio_int_detect_in(pulse[1]), .sdio_int_ack_in(ack),
        .card_busy_in(busy_c), .data_tran_done_in(pulse[2]),
        .cmd_done_in(pulse[3]), .fifo_level_in(level),
        .card_in_read_pause_in(pause_c), .resp_crc_err_in(pulse[4]),
        .read_crc_err_in(pulse[5]), .wr_crc_valid_in(pulse[6]),
        .wr_crc_code_in(code_c), .resp_timeout_in(pulse[7]),
        .read_timeout_in(pulse[8]), .ctrl_reset_out(rst_o),
        .op_start_out(op_o), .card_clk_running_out(run_o),
        .card_clk_tick_out(tick));

    card_side_model card_u (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
        .ev_in(ev), .code_in(code), .busy_in(busy), .pause_in(pause),
        .tick_in(tick), .pulse_out(pulse), .code_out(code_c),
        .busy_out(busy_c), .pause_out(pause_c), .ticks_out(ticks));

    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk_in);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_in);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic stat(input logic [31:0] exp);
        rd_reg(card_host_pkg::STAT_OFS, got);
        check("status", got, exp);
    endtask

    task automatic ctl(input logic [31:0] d);
        wr_reg(card_host_pkg::CTRL_OFS, d);
    endtask

    // Card event, with the host acknowledge landing beside its pulse
    task automatic fire(input logic [8:0] m, input logic a);
        @(posedge ref_clk_in);
        ev <= m;
        @(posedge ref_clk_in);
        ev <= 9'h000;
        ack <= a;
        @(posedge ref_clk_in);
        ack <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
    endtask

    task automatic wrap_up;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk_in);
        fail_count++;
        wrap_up;
    end

    initial begin
        repeat (6) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        stat(32'h0000_8040);
        check("reset_out", 32'(rst_o), 32'h1);
        repeat (20) @(posedge ref_clk_in);
        stat(IDLE);
        check("reset_out", 32'(rst_o), 32'h0);
        rd_reg(card_host_pkg::CLKDIV_OFS, got);
        check("divider", got, 32'h0000_0007);
        rd_reg(8'h0C, got);
        check("unmapped", got, 32'h0000_0000);
        for (int i = 0; i < 9; i++) begin
            if (i != 1 && i != 6) begin
                fire(9'(1 << i), 1'b0);
                stat(IDLE | (32'h1 << bit_of[i]));
                wr_reg(card_host_pkg::STAT_OFS, 32'h0000_0000);
                stat(IDLE | (32'h1 << bit_of[i]));
                ctl(32'h0000_0004);
                #1;
                check("op_start", 32'(op_o), 32'h1);
                stat(IDLE);
            end
        end
        for (int c = 0; c < 4; c++) begin
            code <= 2'(c);
            fire(9'h040, 1'b0);
            stat(IDLE | ((c == 3) ? 32'h0 : 32'(c << 2)));
            ctl(32'h0000_0004);
        end
        fire(9'h002, 1'b0);
        ctl(32'h0000_0004);
        stat(IDLE | 32'h4000);
        fire(9'h000, 1'b1);
        stat(IDLE);
        fire(9'h002, 1'b1);
        stat(IDLE | 32'h4000);
        fire(9'h000, 1'b1);
        for (int i = 0; i < 5; i++) begin
            level <= lv[i];
            repeat (3) @(posedge ref_clk_in);
            stat(lx[i]);
        end
        level <= 5'h00;
        busy <= 1'b1;
        pause <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        stat(32'h0000_0240);
        busy <= 1'b0;
        pause <= 1'b0;
        wr_reg(card_host_pkg::CLKDIV_OFS, 32'hFFFF_FFF8);
        rd_reg(card_host_pkg::CLKDIV_OFS, got);
        check("divider", got, 32'h0000_0000);
        ctl(32'h0000_0002);
        stat(IDLE | 32'h0100);
        check("running", 32'(run_o), 32'h1);
        for (int r = 0; r < 8; r++) begin
            wr_reg(card_host_pkg::CLKDIV_OFS, 32'(r));
            repeat (140) @(posedge ref_clk_in);
            #1;
            t0 = ticks;
            repeat (256) @(posedge ref_clk_in);
            #1;
            check("ticks", 32'(ticks - t0), 32'(256 >> r));
        end
        ctl(32'h0000_0000);
        stat(IDLE | 32'h0100);
        ctl(32'h0000_0001);
        repeat (3) @(posedge ref_clk_in);
        #1;
        t0 = ticks;
        repeat (300) @(posedge ref_clk_in);
        #1;
        check("ticks", 32'(ticks - t0), 32'h0000_0000);
        stat(IDLE);
        check("running", 32'(run_o), 32'h0);
        fire(9'h008, 1'b0);
        ctl(32'h0000_0008);
        stat(32'h0000_8040);
        check("reset_out", 32'(rst_o), 32'h1);
        repeat (20) @(posedge ref_clk_in);
        stat(IDLE);
        wrap_up;
    end
endmodule
